// *** core/emwg_pkg.sv ***
package emwg_pkg;
	// half-period unit: one ref_clk_i cycle is one half-cycle of the output clock
	localparam int unsigned REF_CLK_MHZ     = 50;
	localparam int unsigned T_STATE_COUNT   = 6;
	// state lengths in half_cycle_unit, each at least one
	localparam logic [3:0]  STATE_LEN_DEF   = 4'h2;
	// request sampled to address float: three units after next rising edge
	localparam logic [2:0]  FLOAT_DELAY     = 3'h2;
	localparam logic [2:0]  GRANT_DELAY     = 3'h1;
	localparam logic [15:0] REFRESH_IVL_DEF = 16'h0048;
	localparam logic [3:0]  ONE4            = 4'h1;
	localparam logic [15:0] ONE16           = 16'h0001;
	localparam logic [2:0]  ONE3            = 3'h1;

	typedef enum logic [2:0] {
		EMWG_IDLE,
		EMWG_T1,
		EMWG_T2,
		EMWG_T3,
		EMWG_T4,
		EMWG_T5,
		EMWG_T6
	} emwg_cyc_type;

	typedef enum logic [1:0] {
		EMWG_BUS,
		EMWG_FLOAT_WAIT,
		EMWG_GRANT_WAIT,
		EMWG_GRANTED
	} emwg_dma_type;
endpackage : emwg_pkg

// *** core/emwg_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for the asynchronous bus request
module emwg_sync (
	input  wire logic ref_clk_i,    // system clock
	input  wire logic reset_n_i,    // sync reset, active low
	input  wire logic async_i,      // asynchronous level
	output logic      sync_o        // synchronised level
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// first flop feeds only the second
	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule // emwg_sync
`default_nettype wire

// *** core/emwg_core.sv ***
// Operation
// (RULE1) wait high stretches state four
// (RULE2) wait sampled on falling edge in T3
// (RULE3) wait strobe falls on rising edge
// (RULE4) wait acts in every external cycle
// (RULE5) on-chip accesses ignore wait
// (RULE6) after waits, T5 starts on rising edge
// (RULE7) wait low two units before reraise
// (RULE8) refreshes overdue during wait are dropped
// (RULE9) request sampled last unit of T6
// (RULE10) master raises request two units early
// (RULE11) idle: request sampled every low phase
// (RULE12) float two after rise, grant one later; code floats three units after the rise
// (RULE13) release: grant drops at falling edge
// (RULE14) bus resumes at next rising edge
// (RULE15) master drops request at falling edge
// (RULE16) strobes inactive while granted
// (RULE17) no cut cycles; pending refresh first
// (RULE18) on-chip runs; external waits for grant
// (RULE19) long dma holder refreshes memory itself
// (RULE20) request through reset grants before boot
// (RULE21) request one input period before reset
// (RULE22) idle grant within four to seven units
// (RULE23) refresh-due never floated
// (RULE24) logic clocked at twice output clock
`timescale 1ns/1ps
`default_nettype none
module emwg_core (
	input  wire logic ref_clk_i,              // twice cpu_clock_output rate
	input  wire logic reset_n_i,              // sync reset, active low
	input  wire logic ext_req_i,              // external cycle wanted (level)
	input  wire logic onchip_req_i,           // on-chip access wanted
	input  wire logic wait_extend_in_i,       // external wait input
	input  wire logic bus_request_in_i,       // asynchronous dma request
	input  wire logic boot_start_i,           // bootstrap about to begin
	output logic      cpu_clock_output_o,     // processor output clock
	output logic      bus_grant_out_o,        // dma grant
	output logic      addr_oe_o,              // address bus drive enable
	output logic      strobe_four_n_o,        // strobe four, active low
	output logic      cycle_active_o,         // external cycle in progress
	output logic      refresh_cycle_o,        // current cycle is refresh
	output logic      refresh_due_out_o,      // refresh pending, never floated
	output logic      ext_done_o,             // external cycle ended (pulse)
	output logic      onchip_ack_o,           // on-chip access served (level, follows request one unit later)
	output logic      boot_hold_o             // hold bootstrap until grant
);
	import emwg_pkg::*;

	logic           req_s;
	emwg_cyc_type   cyc_q, cyc_d;
	emwg_dma_type   dma_q, dma_d;
	logic           phase_q, phase_d;     // 1: high half of output clock
	logic [3:0]     len_q, len_d;
	logic           waited_q, waited_d;
	logic           wait_smp_q, wait_smp_d;
	logic           is_rf_q, is_rf_d;
	logic           rf_due_q, rf_due_d;
	logic [15:0]    rf_cnt_q, rf_cnt_d;
	logic [2:0]     dly_q, dly_d;
	logic           oe_q, oe_d;
	logic           gnt_q, gnt_d;
	logic           s4_q, s4_d;
	logic           done_q, done_d;
	logic           oc_q, oc_d;
	logic           boot_q, boot_d;
	logic           act_q, act_d;     // registered cycle-active flag
	logic           end_t;

	emwg_sync u_req_sync (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (bus_request_in_i),
		.sync_o    (req_s)
	);

	// true when the next edge is a rising edge of the output clock
	function automatic logic rise_next(input logic ph);
		return !ph;
	endfunction

	assign end_t = (len_q == ONE4);

	// cycle sequencer, clock divider, refresh timer
	always_comb begin
		cyc_d      = cyc_q;
		phase_d    = !phase_q;                       // RULE24
		len_d      = len_q - ONE4;
		waited_d   = waited_q;
		wait_smp_d = wait_smp_q;
		is_rf_d    = is_rf_q;
		rf_due_d   = rf_due_q;
		rf_cnt_d   = rf_cnt_q - ONE16;
		done_d     = 1'b0;
		oc_d       = onchip_req_i;                   // wait never looked at: RULE5 RULE18
		if (rf_cnt_q == ONE16) begin
			rf_cnt_d = REFRESH_IVL_DEF;
			rf_due_d = 1'b1;                         // repeat tick is absorbed: RULE8
		end
		case (cyc_q)
			EMWG_IDLE: begin
				len_d = STATE_LEN_DEF;
				// start only on a rising edge and never while granted;
				// a due refresh goes ahead of a waiting request; an external request waits while dma is requested
				if (dma_q == EMWG_BUS && rise_next(phase_q)) begin // RULE14 RULE17
					if (rf_due_q) begin
						cyc_d    = EMWG_T1;
						is_rf_d  = 1'b1;
						rf_due_d = 1'b0;
					end else if (ext_req_i && !req_s) begin
						cyc_d   = EMWG_T1;
						is_rf_d = 1'b0;
					end
					waited_d = 1'b0;
				end
			end
			EMWG_T3: begin
				// sample on the falling edge within T3, any cycle type
				if (phase_q)
					wait_smp_d = wait_extend_in_i;           // RULE2 RULE4
				if (end_t)
					cyc_d = EMWG_T4;
			end
			EMWG_T4: begin
				if (end_t && wait_smp_q) begin
					len_d      = ONE4;                   // RULE1
					waited_d   = 1'b1;
					wait_smp_d = wait_extend_in_i;
				end else if (end_t && waited_q && !rise_next(phase_q)) begin
					len_d = ONE4;                        // extra_align_wait RULE6
					waited_d = 1'b0;
				end else if (end_t) begin
					cyc_d = EMWG_T5;
				end
			end
			EMWG_T6: begin
				if (end_t) begin
					cyc_d  = EMWG_IDLE;
					done_d = !is_rf_q;
				end
			end
			default: begin
				if (end_t)
					cyc_d = emwg_cyc_type'(cyc_q + ONE3);
			end
		endcase
		// every new state starts with a full length
		if (cyc_d != cyc_q)
			len_d = STATE_LEN_DEF;
		// strobe four low exactly while T4 is held, never under a grant
		s4_d  = (cyc_d != EMWG_T4) || (dma_q == EMWG_GRANTED); // RULE16
		act_d = (cyc_d != EMWG_IDLE);
	end

	// dma handshake; request taken only in low phases or end of T6
	always_comb begin
		dma_d  = dma_q;
		dly_d  = dly_q;
		oe_d   = oe_q;
		gnt_d  = gnt_q;
		boot_d = (boot_q | (boot_start_i & req_s)) & !gnt_q; // RULE20
		case (dma_q)
			EMWG_BUS: begin
				// idle low phase, or last unit of T6: RULE9 RULE11
				if (req_s && !rf_due_q && ((cyc_q == EMWG_IDLE && !phase_q) ||
						(cyc_q == EMWG_T6 && end_t))) begin // RULE9 RULE11 RULE17
					dma_d = EMWG_FLOAT_WAIT;
					dly_d = FLOAT_DELAY + ONE3;          // counts past next rising edge
				end
			end
			EMWG_FLOAT_WAIT: begin
				dly_d = dly_q - ONE3;
				if (dly_q == ONE3) begin
					oe_d  = 1'b0;                        // RULE12
					dma_d = EMWG_GRANT_WAIT;
					dly_d = GRANT_DELAY;
				end
			end
			EMWG_GRANT_WAIT: begin
				gnt_d = 1'b1;                            // RULE12 RULE22
				dma_d = EMWG_GRANTED;
			end
			EMWG_GRANTED: begin
				// removal seen in high phase, drop at next falling edge
				if (!req_s && phase_q) begin             // RULE13
					gnt_d = 1'b0;
					oe_d  = 1'b1;
					dma_d = EMWG_BUS;
				end
			end
			default: dma_d = EMWG_BUS;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			cyc_q      <= EMWG_IDLE;
			dma_q      <= EMWG_BUS;
			phase_q    <= 1'b0;
			len_q      <= STATE_LEN_DEF;
			waited_q   <= 1'b0;
			wait_smp_q <= 1'b0;
			is_rf_q    <= 1'b0;
			rf_due_q   <= 1'b0;
			rf_cnt_q   <= REFRESH_IVL_DEF;
			dly_q      <= 3'h0;
			oe_q       <= 1'b1;
			gnt_q      <= 1'b0;
			s4_q       <= 1'b1;
			done_q     <= 1'b0;
			oc_q       <= 1'b0;
			boot_q     <= 1'b0;
			act_q      <= 1'b0;
		end else begin
			cyc_q      <= cyc_d;
			dma_q      <= dma_d;
			phase_q    <= phase_d;
			len_q      <= len_d;
			waited_q   <= waited_d;
			wait_smp_q <= wait_smp_d;
			is_rf_q    <= is_rf_d;
			rf_due_q   <= rf_due_d;
			rf_cnt_q   <= rf_cnt_d;
			dly_q      <= dly_d;
			oe_q       <= oe_d;
			gnt_q      <= gnt_d;
			s4_q       <= s4_d;
			done_q     <= done_d;
			oc_q       <= oc_d;
			boot_q     <= boot_d;
			act_q      <= act_d;
		end
	end

	// outputs straight from flops
	assign cpu_clock_output_o = phase_q;
	assign bus_grant_out_o    = gnt_q;
	assign addr_oe_o          = oe_q;
	assign strobe_four_n_o    = s4_q;
	assign cycle_active_o     = act_q;
	assign refresh_cycle_o    = is_rf_q;
	assign refresh_due_out_o  = rf_due_q;                // RULE23
	assign ext_done_o         = done_q;
	assign onchip_ack_o       = oc_q;
	assign boot_hold_o        = boot_q;

	chk_grant_after_float: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(oe_q) |=> gnt_q) else $error("grant not one unit after float"); // RULE12
	chk_strobe_idle_dma: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		gnt_q |-> s4_q) else $error("strobe active during grant"); // RULE16
	chk_no_cycle_grant: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		gnt_q |-> cyc_q == EMWG_IDLE) else $error("cycle during grant"); // RULE17
	chk_grant_drop_fall: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(gnt_q) |-> !phase_q) else $error("grant fell off falling edge"); // RULE13
	chk_start_rising: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(cyc_q == EMWG_T1) |-> phase_q) else $error("cycle began off rising edge"); // RULE14
	chk_t5_aligned: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cyc_q == EMWG_T4 && cyc_d == EMWG_T5 && waited_q) |=> phase_q)
		else $error("T5 misaligned after wait"); // RULE6
	chk_grant_latency: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(dma_q == EMWG_BUS && dma_d == EMWG_FLOAT_WAIT) |-> ##[4:7] gnt_q)
		else $error("grant latency out of range"); // RULE22
	chk_wait_stretch: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cyc_q == EMWG_T4 && end_t && wait_smp_q) |=> cyc_q == EMWG_T4)
		else $error("wait did not stretch T4"); // RULE1
	chk_boot_hold_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		gnt_q |=> !boot_q) else $error("boot hold kept under grant"); // RULE20
endmodule // emwg_core
`default_nettype wire

// *** testbench/emwg_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// dma master plus wait logic on the far side of the bus
module emwg_partner (
	input  wire logic       ref_clk_i,        // system clock
	input  wire logic       cpu_clock_i,      // processor output clock
	input  wire logic       cycle_active_i,   // external cycle running
	input  wire logic       dma_go_i,         // bench wants the bus
	input  wire logic [3:0] wait_units_i,     // extra wait, 0 = none
	output logic            bus_request_in_o, // dma request
	output logic            wait_extend_in_o  // wait input
);
	logic [3:0] left_q = 4'h0;
	logic       act_q = 1'b0;
	logic       req_q = 1'b0;  // known low before the first high phase
	// request moves in the high phase only, so a drop meets a falling edge
	always @(posedge ref_clk_i) begin
		if (cpu_clock_i) req_q <= dma_go_i;
	end
	assign bus_request_in_o = req_q;
	// wait held steady from cycle start across T3, then dropped for good
	always @(posedge ref_clk_i) begin
		act_q <= cycle_active_i;
		if (cycle_active_i && !act_q && wait_units_i != 4'h0)
			left_q <= 4'h6 + wait_units_i;
		else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
	// one drop per cycle keeps the line low far longer than two units
	assign wait_extend_in_o = (left_q != 4'h0);
endmodule // emwg_partner
`default_nettype wire

// *** testbench/ext_mem_wait_and_dma_grant_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_mem_wait_and_dma_grant_bench;
	import emwg_pkg::*;
	logic       clk, rst_n, ext_req, onchip_req, boot_start, dma_go;
	logic [3:0] wait_units;
	wire logic  cpu_clk, grant, addr_oe, s4_n, active, rf_cyc, rf_due, done, ack, hold, req, wt;
	int         fail_count, compares, n;
	emwg_core u_emwg_core (.ref_clk_i(clk), .reset_n_i(rst_n), .ext_req_i(ext_req),
		.onchip_req_i(onchip_req), .wait_extend_in_i(wt), .bus_request_in_i(req),
		.boot_start_i(boot_start), .cpu_clock_output_o(cpu_clk), .bus_grant_out_o(grant),
		.addr_oe_o(addr_oe), .strobe_four_n_o(s4_n), .cycle_active_o(active),
		.refresh_cycle_o(rf_cyc), .refresh_due_out_o(rf_due), .ext_done_o(done),
		.onchip_ack_o(ack), .boot_hold_o(hold));
	emwg_partner u_emwg_partner (.ref_clk_i(clk), .cpu_clock_i(cpu_clk),
		.cycle_active_i(active), .dma_go_i(dma_go), .wait_units_i(wait_units),
		.bus_request_in_o(req), .wait_extend_in_o(wt));
	// 20 ns clock, one half_cycle_unit per cycle
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// step past the edge so its updates have landed
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic release_bus();
		dma_go <= 1'b0;
		n = 0;
		while (grant !== 1'b0 && n < 30) begin tick(); n++; end
	endtask
	task automatic t_dma_idle();
		logic oe_prev;
		logic due;
		logic bad;
		logic oc_bad;
		dma_go <= 1'b1;
		n = 0;
		while (req !== 1'b1 && n < 8) begin tick(); n++; end
		n = 0;
		oe_prev = addr_oe;
		while (grant !== 1'b1 && n < 20) begin oe_prev = addr_oe; tick(); n++; end
		check("grant delay", 8'h01, {7'h0, n >= 4 && n <= 7});
		check("float first", 8'h00, {7'h0, oe_prev});
		due = 1'b0;
		bad = 1'b0;
		oc_bad = 1'b0;
		onchip_req <= 1'b1;
		ext_req <= 1'b1;
		// hold past one refresh interval so a refresh falls due meanwhile
		repeat (80) begin
			tick();
			bad |= (s4_n !== 1'b1) | (addr_oe !== 1'b0);
			due |= (rf_due === 1'b1);
			oc_bad |= (ack !== 1'b1) | (active !== 1'b0);
		end
		onchip_req <= 1'b0;
		ext_req <= 1'b0;
		check("strobes idle", 8'h00, {7'h0, bad});
		check("due shown", 8'h01, {7'h0, due});
		check("onchip during dma", 8'h00, {7'h0, oc_bad});
		release_bus();
		check("grant drop phase", 8'h00, {7'h0, cpu_clk});
		n = 0;
		while (active !== 1'b1 && n < 12) begin tick(); n++; end
		tick();
		check("refresh next", 8'h01, {7'h0, rf_cyc});
		while (active === 1'b1 && n < 40) begin tick(); n++; end
	endtask
	task automatic t_ext(input logic [3:0] w);
		logic [7:0] low;
		logic       ack_ok;
		wait_units <= w;
		ext_req <= 1'b1;
		onchip_req <= 1'b1;
		low = 8'h00;
		ack_ok = 1'b1;
		n = 0;
		while (s4_n !== 1'b0 && n < 30) begin tick(); n++; end
		while (s4_n === 1'b0 && n < 60) begin ack_ok &= (ack === 1'b1); low++; tick(); n++; end
		check("t5 phase", 8'h01, {7'h0, cpu_clk});
		check("onchip served", 8'h01, {7'h0, ack_ok});
		if (w == 4'h0)
			check("t4 plain", {4'h0, STATE_LEN_DEF}, low);
		else
			check("t4 stretched", 8'h01, {7'h0, low > 8'h02 && !low[0]});
		while (done !== 1'b1 && n < 80) begin tick(); n++; end
		check("cycle done", 8'h01, {7'h0, done});
		ext_req <= 1'b0;
		onchip_req <= 1'b0;
		repeat (2) tick();
	endtask
	task automatic t_dma_busy();
		logic early;
		ext_req <= 1'b1;
		wait_units <= 4'h2;
		n = 0;
		while (active !== 1'b1 && n < 30) begin tick(); n++; end
		dma_go <= 1'b1;
		early = 1'b0;
		while (active === 1'b1 && n < 60) begin early |= (grant !== 1'b0); tick(); n++; end
		ext_req <= 1'b0;
		check("no cut cycle", 8'h00, {7'h0, early});
		n = 0;
		while (grant !== 1'b1 && n < 30) begin tick(); n++; end
		check("grant after cycle", 8'h01, {7'h0, grant});
		release_bus();
	endtask
	task automatic t_boot();
		logic seen;
		dma_go <= 1'b1;
		repeat (4) tick();
		rst_n <= 1'b0;
		repeat (8) tick();
		rst_n <= 1'b1;
		boot_start <= 1'b1;
		n = 0;
		seen = 1'b0;
		while (grant !== 1'b1 && n < 20) begin seen |= (hold === 1'b1); tick(); n++; end
		check("grant before boot", 8'h01, {7'h0, grant});
		check("hold before grant", 8'h01, {7'h0, seen});
		tick();
		check("hold cleared", 8'h00, {7'h0, hold});
		release_bus();
		boot_start <= 1'b0;
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		ext_req = 1'b0;
		onchip_req = 1'b0;
		boot_start = 1'b0;
		dma_go = 1'b0;
		wait_units = 4'h0;
		fail_count = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		tick();
		check("reset grant", 8'h00, {7'h0, grant});
		check("reset strobe", 8'h01, {7'h0, s4_n});
		t_dma_idle();
		for (int i = 0; i < 4; i++) t_ext(4'(i));
		t_dma_busy();
		t_boot();
		final_report();
	end
	// watchdog far beyond the few hundred cycles the tests take
	initial begin
		#(20 * 20000);
		fail_count++;
		final_report();
	end
endmodule // ext_mem_wait_and_dma_grant_bench
`default_nettype wire
